//--- pkg/dac_serial_regs.vh
// constants for the serial-load converter front end
// assumes inclusion by bare name from rtl files
`ifndef DAC_SERIAL_REGS_VH
`define DAC_SERIAL_REGS_VH
`define FRAME_BITS 24
`define CODE_BITS 18
`define CODE_MSB 17
`define BITCNT_W 5
`define CODE_ZERO 18'h0_0000
`define CODE_MID 18'h2_0000
`define WORD_ZERO 24'h00_0000
`define FIFO_WIDTH 18
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

//--- rtl/code_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module code_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire nrst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_ff;
  reg [AW:0] rdPtr_ff;
  wire [AW:0] used;
  wire doWrite;
  wire doRead;
  assign used = wrPtr_ff - rdPtr_ff;
  assign inReady = (used != DEPTH[AW:0]) | (DEPTH == (1 << AW) ? used[AW] == 1'b0 : 1'b0);
  assign outValid = (used != {(AW+1){1'b0}});
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;
  assign outData = mem[rdPtr_ff[AW-1:0]];
  always @(posedge clock)
  begin
    if (doWrite)
    begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_ff <= {(AW+1){1'b0}};
      rdPtr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doRead)
      begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end
endmodule // code_fifo
`default_nettype wire

//--- rtl/dac_serial_load.v
// serial load, input register and output latch of an 18-bit converter front end
// assumes all pins asynchronous to clock; serial clock is oversampled
`timescale 1ns/1ps
`default_nettype none
`include "dac_serial_regs.vh"
module dac_serial_load (
  input wire clock,
  input wire nrst,
  input wire serialClk,
  input wire serialIn,
  input wire chipSelect_n,
  output reg serialOut,
  output reg serialOutEn,
  input wire hwReset_n,
  input wire reset_level_select,
  input wire format_select,
  input wire readout_mode_select,
  input wire load_output_n,
  input wire power_down_pin,
  output reg [17:0] outputCode,
  output reg [17:0] ladderCode,
  output reg outputGrounded,
  output wire [17:0] inputRegCode,
  output wire frameOverflow
);
  // two-stage synchronisers for every pin
  reg [1:0] sclkSync_ff;
  reg [1:0] sdiSync_ff;
  reg [1:0] csSync_ff;
  reg [1:0] rstSync_ff;
  reg [1:0] lvlSync_ff;
  reg [1:0] fmtSync_ff;
  reg [1:0] modeSync_ff;
  reg [1:0] loadSync_ff;
  reg [1:0] pdnSync_ff;
  reg sclkPrev_ff;
  reg csPrev_ff;
  reg [23:0] shiftReg_ff;
  reg [23:0] readback_ff;
  reg [4:0] bitCount_ff;
  reg overflow_ff;
  reg [17:0] inputReg_ff;
  reg [17:0] latch_ff;
  reg pendingLoad_ff;
  reg frameStandAlone_ff;
  reg nxt_serialOut;
  wire sclkRise;
  wire sclkFall;
  wire csRise;
  wire csFall;
  wire csLow;
  wire hwResetActive;
  wire standAlone;
  wire [17:0] resetCode;
  wire frameValid;
  wire fifoInReady;
  wire fifoOutValid;
  wire [17:0] fifoOutData;
  wire fifoPop;
  wire queuePush;
  // clear values match the idle pin levels except hwReset_n, which clears as asserted; no false edge follows reset
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sclkSync_ff <= 2'h0;
      sdiSync_ff <= 2'h0;
      csSync_ff <= 2'h3;
      rstSync_ff <= 2'h0;
      lvlSync_ff <= 2'h0;
      fmtSync_ff <= 2'h3;
      modeSync_ff <= 2'h3;
      loadSync_ff <= 2'h3;
      pdnSync_ff <= 2'h0;
      sclkPrev_ff <= 1'b0;
      csPrev_ff <= 1'b1;
    end
    else
    begin
      sclkSync_ff <= {sclkSync_ff[0], serialClk};
      sdiSync_ff <= {sdiSync_ff[0], serialIn};
      csSync_ff <= {csSync_ff[0], chipSelect_n};
      rstSync_ff <= {rstSync_ff[0], hwReset_n};
      lvlSync_ff <= {lvlSync_ff[0], reset_level_select};
      fmtSync_ff <= {fmtSync_ff[0], format_select};
      modeSync_ff <= {modeSync_ff[0], readout_mode_select};
      loadSync_ff <= {loadSync_ff[0], load_output_n};
      pdnSync_ff <= {pdnSync_ff[0], power_down_pin};
      sclkPrev_ff <= sclkSync_ff[1];
      csPrev_ff <= csSync_ff[1];
    end
  end
  assign csLow = ~csSync_ff[1];
  assign sclkRise = sclkSync_ff[1] & ~sclkPrev_ff & csLow;
  assign sclkFall = ~sclkSync_ff[1] & sclkPrev_ff & csLow;
  assign csRise = csSync_ff[1] & ~csPrev_ff;
  assign csFall = ~csSync_ff[1] & csPrev_ff;
  assign hwResetActive = ~rstSync_ff[1];
  assign standAlone = modeSync_ff[1];
  // reset code depends only on the level pin, not the format
  assign resetCode = lvlSync_ff[1] ? `CODE_MID : `CODE_ZERO;
  assign frameValid = overflow_ff | (bitCount_ff == `FRAME_BITS);
  assign inputRegCode = inputReg_ff;
  assign frameOverflow = overflow_ff;
  // shift register has no reset so resets never clear it
  always @(posedge clock)
  begin
    if (sclkRise)
    begin
      shiftReg_ff <= {shiftReg_ff[22:0], sdiSync_ff[1]};
    end
  end
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      bitCount_ff <= 5'h0;
      overflow_ff <= 1'b0;
    end
    else if (csFall)
    begin
      // counter stops at a full frame; a further rise flags the overflow
      bitCount_ff <= 5'h0;
      overflow_ff <= 1'b0;
    end
    else if (sclkRise)
    begin
      if (bitCount_ff == `FRAME_BITS - 1)
      begin
        overflow_ff <= overflow_ff;
      end
      if (bitCount_ff == `FRAME_BITS)
      begin
        overflow_ff <= 1'b1;
      end
      else
      begin
        bitCount_ff <= bitCount_ff + 5'h1;
      end
    end
  end
  // readback word: input register in stand-alone mode, zero-filled afterwards
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      readback_ff <= `WORD_ZERO;
    end
    else if (csFall)
    begin
      readback_ff <= {6'h00, inputReg_ff};
    end
    else if (sclkFall)
    begin
      readback_ff <= {readback_ff[22:0], 1'b0};
    end
  end
  // readout mode is frozen for the whole frame so a pin change cannot split it
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      frameStandAlone_ff <= 1'b1;
    end
    else if (csFall)
    begin
      frameStandAlone_ff <= standAlone;
    end
  end
  // output changes at the chip select falling edge and on falling serial clock edges
  always @*
  begin
    nxt_serialOut = serialOut;
    if (csFall)
    begin
      // readback msb is always zero, so the first bit needs no shift
      nxt_serialOut = standAlone ? 1'b0 : shiftReg_ff[23];
    end
    else if (sclkFall)
    begin
      if (frameStandAlone_ff)
      begin
        // bit 23 left at the chip select edge; each fall moves one bit on
        nxt_serialOut = readback_ff[22];
      end
      else
      begin
        nxt_serialOut = shiftReg_ff[23];
      end
    end
  end
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end
    else
    begin
      serialOutEn <= csLow;
      serialOut <= nxt_serialOut;
    end
  end
  // a valid frame is pushed at the chip select rising edge
  assign queuePush = csRise & frameValid & ~hwResetActive & fifoInReady;
  // completed frames queue here before the input register takes them
  code_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) frameQueue (
    .clock(clock),
    .nrst(nrst),
    .inValid(queuePush),
    .inReady(fifoInReady),
    .inData(shiftReg_ff[`CODE_MSB:0]),
    .outValid(fifoOutValid),
    .outReady(1'b1),
    .outData(fifoOutData)
  );
  // the queue is drained every cycle, even under hardware reset; fifoPop only stops the input register taking the word
  assign fifoPop = fifoOutValid & ~hwResetActive;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      inputReg_ff <= `CODE_ZERO;
      latch_ff <= `CODE_ZERO;
      pendingLoad_ff <= 1'b1;
    end
    else if (pendingLoad_ff | hwResetActive)
    begin
      // power-on and hardware reset load the selected reset value
      inputReg_ff <= resetCode;
      latch_ff <= resetCode;
      // one more load after the reset pin clears, when the level pin has settled
      pendingLoad_ff <= hwResetActive;
    end
    else
    begin
      if (fifoPop)
      begin
        inputReg_ff <= fifoOutData;
      end
      if (~loadSync_ff[1])
      begin
        latch_ff <= fifoPop ? fifoOutData : inputReg_ff;
      end
    end
  end
  // ladder code: twos complement flips the msb to reach offset binary
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ladderCode <= `CODE_ZERO;
      outputCode <= `CODE_ZERO;
      outputGrounded <= 1'b0;
    end
    else
    begin
      outputCode <= latch_ff;
      if (fmtSync_ff[1])
      begin
        ladderCode <= latch_ff;
      end
      else
      begin
        ladderCode <= {~latch_ff[`CODE_MSB], latch_ff[16:0]};
      end
      outputGrounded <= pdnSync_ff[1];
    end
  end
endmodule // dac_serial_load
`default_nettype wire

//--- verification/dac_serial_load_checker.sv
// assertions on the converter front end pins
// assumes one clock domain and the top module's ports
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic chipSelect_n,
  input wire logic serialOutEn,
  input wire logic hwReset_n,
  input wire logic reset_level_select,
  input wire logic format_select,
  input wire logic load_output_n,
  input wire logic power_down_pin,
  input wire logic [17:0] outputCode,
  input wire logic [17:0] ladderCode,
  input wire logic outputGrounded,
  input wire logic [17:0] inputRegCode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire logic [17:0] rv = {reset_level_select, 17'h0_0000};
  property p_idle; chipSelect_n[*5] |-> !serialOutEn; endproperty
  a_idle: assert property (p_idle) else $error("out driven idle");
  property p_pdOn; power_down_pin[*4] |-> outputGrounded; endproperty
  a_pdOn: assert property (p_pdOn) else $error("not grounded");
  property p_pdOff; !power_down_pin[*4] |-> !outputGrounded; endproperty
  a_pdOff: assert property (p_pdOff) else $error("still grounded");
  property p_rst;
    (!hwReset_n && $stable(reset_level_select))[*6] |-> inputRegCode == rv && outputCode == rv;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset code");
  property p_bin;
    ($stable(outputCode) && format_select)[*6] |-> ladderCode == outputCode;
  endproperty
  a_bin: assert property (p_bin) else $error("binary ladder");
  property p_twos;
    ($stable(outputCode) && !format_select)[*6] |-> ladderCode == (outputCode ^ 18'h2_0000);
  endproperty
  a_twos: assert property (p_twos) else $error("twos ladder");
  property p_hold; (load_output_n && hwReset_n)[*6] |=> $stable(outputCode); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_load;
    ($stable(inputRegCode) && !load_output_n && hwReset_n)[*5] |-> outputCode == inputRegCode;
  endproperty
  a_load: assert property (p_load) else $error("latch not loaded");
  c_pd: cover property (power_down_pin[*4]);
  c_rst: cover property (!hwReset_n[*6]);
  c_twos: cover property (!format_select[*6]);
endmodule // dac_serial_load_checker
bind dac_serial_load dac_serial_load_checker chk (.clock, .nrst, .chipSelect_n, .serialOutEn,
  .hwReset_n, .reset_level_select, .format_select, .load_output_n, .power_down_pin,
  .outputCode, .ladderCode, .outputGrounded, .inputRegCode);
`default_nettype wire

//--- verification/host_model.sv
// host serial controller sending frames msb first
// assumes the bench calls send; serial clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output var logic serialClk,
  output var logic serialIn,
  output var logic chipSelect_n,
  input wire logic serialOut
);
  integer i;
  // serial output bits seen at each rising serial clock edge of the last frame
  logic [31:0] captured;
  initial
  begin
    serialClk = 1'h0;
    serialIn = 1'h0;
    chipSelect_n = 1'h1;
  end
  task send(input logic [31:0] w, input logic [5:0] n);
    chipSelect_n = 1'h0;
    captured = 32'h0000_0000;
    #100;
    for (i = n; i > 0; i--)
    begin
      serialIn = w[i-1];
      #80 serialClk = 1'h1;
      captured = {captured[30:0], serialOut};
      #80 serialClk = 1'h0;
    end
    #100 chipSelect_n = 1'h1;
    serialIn = ~serialIn;
    #200;
  endtask
endmodule // host_model
`default_nettype wire

//--- verification/tb_dac_serial_load_and_reset.sv
// self-checking bench for the serial-load converter front end
// assumes host_model on the serial pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_dac_serial_load_and_reset;
  logic clock = 1'h0, nrst = 1'h0, hwReset_n = 1'h1, reset_level_select = 1'h1;
  logic format_select = 1'h1, readout_mode_select = 1'h0, load_output_n = 1'h0;
  logic power_down_pin = 1'h0;
  wire serialClk, serialIn, chipSelect_n, serialOut, serialOutEn, outputGrounded, frameOverflow;
  wire [17:0] outputCode, ladderCode, inputRegCode;
  integer fails = 0, nCompared = 0, cycles = 0;
  logic [74:0] r;
  // format, bit count, frame, input code, ladder code
  logic [74:0] rows [7] = '{
    {1'h1, 6'h18, 32'h00FF_FFFF, 18'h3_FFFF, 18'h3_FFFF},
    {1'h1, 6'h18, 32'h0002_0000, 18'h2_0000, 18'h2_0000},
    {1'h0, 6'h18, 32'h0002_0000, 18'h2_0000, 18'h0_0000},
    {1'h0, 6'h18, 32'h0001_FFFF, 18'h1_FFFF, 18'h3_FFFF},
    {1'h0, 6'h1C, 32'h0AC1_2345, 18'h1_2345, 18'h3_2345},
    {1'h0, 6'h14, 32'h0003_0000, 18'h1_2345, 18'h3_2345},
    {1'h1, 6'h18, 32'h0000_0000, 18'h0_0000, 18'h0_0000}};
  dac_serial_load dut (.clock, .nrst, .serialClk, .serialIn, .chipSelect_n, .serialOut,
    .serialOutEn, .hwReset_n, .reset_level_select, .format_select, .readout_mode_select,
    .load_output_n, .power_down_pin, .outputCode, .ladderCode, .outputGrounded,
    .inputRegCode, .frameOverflow);
  host_model host (.serialClk, .serialIn, .chipSelect_n, .serialOut);
  task close_out;
    if (fails == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [17:0] got, input logic [17:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask
  initial
  begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      close_out;
    end
  end
  initial
  begin
    cyc(16);
    nrst = 1'h1;
    cyc(10);
    chk(inputRegCode, 18'h2_0000);
    chk(outputCode, 18'h2_0000);
    foreach (rows[k])
    begin
      r = rows[k];
      format_select = r[74];
      host.send(r[67:36], r[73:68]);
      cyc(30);
      chk(inputRegCode, r[35:18]);
      chk(outputCode, r[35:18]);
      chk(ladderCode, r[17:0]);
    end
    load_output_n = 1'h1;
    host.send(32'h0A00_1111, 6'h1C);
    cyc(30);
    chk(inputRegCode, 18'h0_1111);
    chk(outputCode, 18'h0_0000);
    chk(host.captured[17:0], 18'h0_000A);
    chk({17'h0_0000, frameOverflow}, 18'h0_0001);
    load_output_n = 1'h0;
    cyc(10);
    chk(outputCode, 18'h0_1111);
    readout_mode_select = 1'h1;
    power_down_pin = 1'h1;
    host.send(32'h0F00_2222, 6'h1C);
    cyc(30);
    chk({17'h0_0000, outputGrounded}, 18'h0_0001);
    chk(inputRegCode, 18'h0_2222);
    chk(host.captured[21:4], 18'h0_1111);
    chk({14'h0000, host.captured[3:0]}, 18'h0_0000);
    power_down_pin = 1'h0;
    cyc(10);
    chk({17'h0_0000, outputGrounded}, 18'h0_0000);
    chk(outputCode, 18'h0_2222);
    reset_level_select = 1'h0;
    hwReset_n = 1'h0;
    cyc(10);
    chk(inputRegCode, 18'h0_0000);
    chk(outputCode, 18'h0_0000);
    hwReset_n = 1'h1;
    cyc(4);
    // short frame: its readback is not looked at
    host.send(32'h0000_3333, 6'h0A);
    cyc(30);
    chk(inputRegCode, 18'h0_0000);
    chk({17'h0_0000, frameOverflow}, 18'h0_0000);
    close_out;
  end
endmodule // tb_dac_serial_load_and_reset
`default_nettype wire
